// *** hdl/irq_source_selector.sv ***
// interrupt source selector: sixteen prioritized lines for the processor core
// assumes event inputs synchronous to CLK; core takes line index as priority
//
// Contract
// - exactly sixteen lines, fixed priority by index
// - line 0 highest, line 15 lowest
// - line 0 always the reset event
// - lines 0-3 fixed, no selector field
// - lines 4-15 reset to default sources
// - high register 0x019C0000, low 0x019C0004
// - six 5-bit fields per register reroute
// - codes 4-7 pick external pins 4-7
// - code 8 picks combined dma completion
// - code 3 picks sdram refresh event
// - codes 1,2 timers; unassigned codes idle
// - codes 12-15 pick serial tx/rx events
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module irq_source_selector
   import irq_select_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [31:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic RESET_EVENT,
   input wire logic NMI_EVENT,
   input wire logic EXT_PIN_EVENT_4,
   input wire logic EXT_PIN_EVENT_5,
   input wire logic EXT_PIN_EVENT_6,
   input wire logic EXT_PIN_EVENT_7,
   input wire logic DMA_DONE_EVENT,
   input wire logic SDRAM_REFRESH_EVENT,
   input wire logic TIMER0_EVENT,
   input wire logic TIMER1_EVENT,
   input wire logic SERIAL0_TX_EVENT,
   input wire logic SERIAL0_RX_EVENT,
   input wire logic SERIAL1_TX_EVENT,
   input wire logic SERIAL1_RX_EVENT,
   output logic [`NUM_LINES-1:0] INT_LINES
);

   // ----------------------------------------
   // field extraction
   // ----------------------------------------
   function automatic sel_code_t field_of(input word_t r, input int unsigned k);
      logic [4:0] lsb;
      case (k)
         0: lsb = `SEL_LSB_0;
         1: lsb = `SEL_LSB_1;
         2: lsb = `SEL_LSB_2;
         3: lsb = `SEL_LSB_3;
         4: lsb = `SEL_LSB_4;
         5: lsb = `SEL_LSB_5;
         default: lsb = `SEL_LSB_0;
      endcase
      field_of = r[lsb +: `SEL_FIELD_W];
   endfunction

   selector_state_t state_q;
   selector_state_t state_d;

   logic [`NUM_CODES-1:0] events;
   logic [`NUM_LINES-1:0] routed;

   // ----------------------------------------
   // event vector indexed by selector code
   // ----------------------------------------
   // unassigned and reserved codes stay idle
   always_comb
   begin
      events = '0;
      // timer events on codes 1 and 2
      events[`CODE_TIMER0] = TIMER0_EVENT;
      events[`CODE_TIMER1] = TIMER1_EVENT;
      events[`CODE_SDRAM] = SDRAM_REFRESH_EVENT;
      // external pins on codes 4 to 7
      events[`CODE_EXT4] = EXT_PIN_EVENT_4;
      events[`CODE_EXT5] = EXT_PIN_EVENT_5;
      events[`CODE_EXT6] = EXT_PIN_EVENT_6;
      events[`CODE_EXT7] = EXT_PIN_EVENT_7;
      // combined dma completion on code 8
      events[`CODE_DMA] = DMA_DONE_EVENT;
      // serial port events on codes 12 to 15
      events[`CODE_SER0_TX] = SERIAL0_TX_EVENT;
      events[`CODE_SER0_RX] = SERIAL0_RX_EVENT;
      events[`CODE_SER1_TX] = SERIAL1_TX_EVENT;
      events[`CODE_SER1_RX] = SERIAL1_RX_EVENT;
   end

   // ----------------------------------------
   // fixed lines
   // ----------------------------------------
   // line 0 hard bound to the reset event
   assign routed[0] = RESET_EVENT;
   // nmi fixed; reserved lines 2 and 3 held low
   assign routed[1] = NMI_EVENT;
   assign routed[2] = 1'b0;
   assign routed[3] = 1'b0;

   // ----------------------------------------
   // selectable lines 4 to 15
   // ----------------------------------------
   // low register feeds lines 4-9, high register 10-15
   genvar g;
   generate
      for (g = `FIRST_SELECTABLE; g < `NUM_LINES; g++)
      begin : g_line
         localparam int unsigned K = (g - `FIRST_SELECTABLE) % `SEL_FIELDS_PER_REG;
         localparam bit IS_HIGH = (g - `FIRST_SELECTABLE) >= `SEL_FIELDS_PER_REG;
         sel_code_t code;
         // routing is a plain mux on the stored field
         assign code = IS_HIGH ? field_of(state_q.sel_high, K) : field_of(state_q.sel_low, K);
         route_pick u_pick
         (
            .code(code),
            .events(events),
            .hit(routed[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.rdata = '0;
      // exact address decode of both selector registers
      // a write lands in the field at the next edge
      if (WR && ADDR == `SEL_HIGH_ADDR)
      begin
         // bits 15 and 31 ignore writes
         state_d.sel_high = WDATA & `SEL_WRITE_MASK;
      end
      if (WR && ADDR == `SEL_LOW_ADDR)
      begin
         state_d.sel_low = WDATA & `SEL_WRITE_MASK;
      end
      // unmapped reads return zero
      if (RD && ADDR == `SEL_HIGH_ADDR)
      begin
         state_d.rdata = state_q.sel_high;
      end
      if (RD && ADDR == `SEL_LOW_ADDR)
      begin
         state_d.rdata = state_q.sel_low;
      end
      // sixteen lines, index is priority for the core
      state_d.lines = routed;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_q.sel_high <= `SEL_HIGH_RESET;
         state_q.sel_low <= `SEL_LOW_RESET;
         state_q.rdata <= '0;
         state_q.lines <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // outputs registered to keep glitches off the core inputs
   assign RDATA = state_q.rdata;
   assign INT_LINES = state_q.lines;

endmodule // irq_source_selector

// *** hdl/irq_select_params.svh ***
// constants for the interrupt source selector: offsets, field layout, reset values
// assumes inclusion by bare name from package and modules
`ifndef IRQ_SELECT_PARAMS_SVH
`define IRQ_SELECT_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SEL_HIGH_ADDR 32'h019C0000
`define SEL_LOW_ADDR 32'h019C0004

// ----------------------------------------
// field layout
// ----------------------------------------
`define SEL_FIELD_W 5
`define SEL_FIELDS_PER_REG 6
`define SEL_LSB_0 5'h00
`define SEL_LSB_1 5'h05
`define SEL_LSB_2 5'h0A
`define SEL_LSB_3 5'h10
`define SEL_LSB_4 5'h15
`define SEL_LSB_5 5'h1A
`define SEL_WRITE_MASK 32'h7FFF7FFF

// ----------------------------------------
// reset values and line counts
// ----------------------------------------
`define SEL_LOW_RESET 32'h250718A4
`define SEL_HIGH_RESET 32'h08202D43
`define NUM_LINES 16
`define FIRST_SELECTABLE 4
`define NUM_CODES 32

// ----------------------------------------
// selector codes
// ----------------------------------------
`define CODE_NONE 5'h00
`define CODE_TIMER0 5'h01
`define CODE_TIMER1 5'h02
`define CODE_SDRAM 5'h03
`define CODE_EXT4 5'h04
`define CODE_EXT5 5'h05
`define CODE_EXT6 5'h06
`define CODE_EXT7 5'h07
`define CODE_DMA 5'h08
`define CODE_SER0_TX 5'h0C
`define CODE_SER0_RX 5'h0D
`define CODE_SER1_TX 5'h0E
`define CODE_SER1_RX 5'h0F

`endif

// *** hdl/irq_select_pkg.sv ***
// types for the interrupt source selector
// assumes irq_select_params.svh on the include path
package irq_select_pkg;
`include "irq_select_params.svh"

   typedef logic [`SEL_FIELD_W-1:0] sel_code_t;
   typedef logic [31:0] word_t;

   typedef struct packed {
      word_t sel_high;
      word_t sel_low;
      word_t rdata;
      logic [`NUM_LINES-1:0] lines;
   } selector_state_t;
endpackage

// *** hdl/route_pick.sv ***
// one selectable interrupt line: picks the event named by its code
// assumes the event vector is indexed by selector code
`timescale 1ns/1ps
module route_pick
   import irq_select_pkg::*;
(
   input wire sel_code_t code,
   input wire logic [`NUM_CODES-1:0] events,
   output logic hit
);
   // codes without an event carry a constant zero in the vector
   always_comb
   begin
      hit = events[code];
   end
endmodule // route_pick

// *** testbench/irq_select_monitor.sv ***
// port assertions for the interrupt source selector
// assumes binding onto irq_source_selector, one clock domain
`timescale 1ns/1ps
`include "irq_select_params.svh"
module irq_select_monitor
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [31:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic RESET_EVENT,
   input wire logic NMI_EVENT,
   input wire logic TIMER0_EVENT,
   input wire logic [`NUM_LINES-1:0] INT_LINES
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   line_zero_a: assert property (INT_LINES[0] == $past(RESET_EVENT))
      else $error("line 0 wrong");
   nmi_line_a: assert property (INT_LINES[1] == $past(NMI_EVENT))
      else $error("line 1 wrong");
   spare_lines_a: assert property (INT_LINES[3:2] == 2'b00)
      else $error("line 2 or 3 set");
   idle_rdata_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data not idle");
   unused_bits_a: assert property (RD |=> !RDATA[15] && !RDATA[31])
      else $error("unused bit set");
   unmapped_read_a: assert property (RD && ADDR != `SEL_HIGH_ADDR && ADDR != `SEL_LOW_ADDR |=> RDATA == 32'h0)
      else $error("unmapped read");
   write_read_a: assert property (WR && ADDR == `SEL_LOW_ADDR ##1 !WR ##1 RD && ADDR == `SEL_LOW_ADDR
      |=> RDATA == ($past(WDATA, 3) & 32'h7FFF7FFF)) else $error("readback wrong");
   field_reroute_a: assert property (WR && ADDR == `SEL_HIGH_ADDR && WDATA[25:21] == 5'h01 ##1 TIMER0_EVENT
      |=> INT_LINES[14]) else $error("reroute late");
   low_write_c: cover property (WR && ADDR == `SEL_LOW_ADDR);
   high_read_c: cover property (RD && ADDR == `SEL_HIGH_ADDR);
   line14_c: cover property (INT_LINES[14]);
endmodule // irq_select_monitor

bind irq_source_selector irq_select_monitor mon_u (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .RESET_EVENT(RESET_EVENT), .NMI_EVENT(NMI_EVENT),
   .TIMER0_EVENT(TIMER0_EVENT), .INT_LINES(INT_LINES));

// *** testbench/event_model.sv ***
// peripheral event sources, indexed by selector code
// assumes slot 0 carries the reset event and slot 9 the nmi
`timescale 1ns/1ps
module event_model
(
   input wire logic CLK,
   input wire logic [15:0] req,
   output logic [15:0] ev
);
   initial ev = 16'h0000;
   // flops, as real sources launch off the clock
   always @(posedge CLK)
      ev <= req;
endmodule // event_model

// *** testbench/test_irq_source_selector.sv ***
// self-checking bench for the interrupt source selector
// assumes design, package, checker and event model compiled first
`timescale 1ns/1ps
`include "irq_select_params.svh"
module test_irq_source_selector
   import irq_select_pkg::*;
;
   localparam logic [15:0] live_codes = 16'hF1FE;
   logic CLK = 0, RESET_N = 0, WR = 0, RD = 0, look = 0, rdv = 0;
   word_t ADDR = '0, WDATA = '0, RDATA, got, rnd = 32'h221FD190, lo = 32'h250718A4, hi = 32'h08202D43;
   logic [15:0] req = '0, ev, INT_LINES;
   word_t q[$];
   int n_mismatch = 0, n_tests = 0;
   irq_source_selector dut_u (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .RESET_EVENT(ev[0]), .NMI_EVENT(ev[9]), .EXT_PIN_EVENT_4(ev[4]), .EXT_PIN_EVENT_5(ev[5]),
      .EXT_PIN_EVENT_6(ev[6]), .EXT_PIN_EVENT_7(ev[7]), .DMA_DONE_EVENT(ev[8]), .SDRAM_REFRESH_EVENT(ev[3]),
      .TIMER0_EVENT(ev[1]), .TIMER1_EVENT(ev[2]), .SERIAL0_TX_EVENT(ev[12]), .SERIAL0_RX_EVENT(ev[13]),
      .SERIAL1_TX_EVENT(ev[14]), .SERIAL1_RX_EVENT(ev[15]), .INT_LINES(INT_LINES));
   event_model src_u (.CLK(CLK), .req(req), .ev(ev));
   initial forever #10 CLK = ~CLK;
   function automatic word_t lfsr(word_t s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] route(word_t l, word_t h, logic [15:0] e);
      logic [15:0] r;
      logic [4:0] c;
      r = {14'h0, e[9], e[0]};
      for (int k = 0; k < 12; k++)
      begin
         c = k < 6 ? l[k * 5 + (k > 2) +: 5] : h[(k - 6) * 5 + (k > 8) +: 5];
         r[k + 4] = e[c[3:0]] & live_codes[c[3:0]] & !c[4];
      end
      return r;
   endfunction
   task automatic bus(logic w, word_t a, word_t d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= w;
      RD <= !w;
      if (!w)
         q.push_back(d);
      @(posedge CLK);
      WR <= 1'b0;
      RD <= 1'b0;
   endtask
   // events land one cycle in the model, one more in the design
   task automatic lines(logic [15:0] e);
      @(posedge CLK);
      req <= e;
      repeat (2) @(posedge CLK);
      q.push_back({16'h0, route(lo, hi, e)});
      look <= 1'b1;
      @(posedge CLK);
      look <= 1'b0;
   endtask
   task automatic summarize();
      // an expectation never looked at is a lost check
      if (q.size() != 0)
         n_mismatch++;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge CLK)
   begin
      if (rdv || look)
      begin
         got = rdv ? RDATA : {16'h0, INT_LINES};
         n_tests++;
         if (q.size() == 0 || got !== q.pop_front())
         begin
            n_mismatch++;
            $display("BAD %0t got %h", $time, got);
         end
      end
      rdv = RD;
   end
   initial
   begin
      #200000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      repeat (12) @(posedge CLK);
      RESET_N <= 1'b1;
      bus(0, `SEL_HIGH_ADDR, hi);
      bus(0, `SEL_LOW_ADDR, lo);
      for (int c = 0; c < 16; c++)
         lines(16'h0001 << c);
      bus(1, 32'h019C0008, 32'hFFFFFFFF);
      bus(0, 32'h019C0008, 32'h0);
      // a loose decode would have let the stray write land here
      bus(0, `SEL_HIGH_ADDR, hi);
      bus(0, `SEL_LOW_ADDR, lo);
      for (int i = 0; i < 40; i++)
      begin
         rnd = lfsr(rnd);
         bus(1, `SEL_HIGH_ADDR, rnd & 32'hBDEFBDEF);
         hi = rnd & 32'h3DEF3DEF;
         rnd = lfsr(rnd);
         bus(1, `SEL_LOW_ADDR, rnd & 32'hBDEFBDEF);
         lo = rnd & 32'h3DEF3DEF;
         bus(0, `SEL_LOW_ADDR, lo);
         bus(0, `SEL_HIGH_ADDR, hi);
         lines(rnd[31:16]);
      end
      // mid-run reset; events go quiet first so line 0 and 1 checks see no stale edge
      req <= 16'h0000;
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      lo = `SEL_LOW_RESET;
      hi = `SEL_HIGH_RESET;
      bus(0, `SEL_LOW_ADDR, lo);
      bus(0, `SEL_HIGH_ADDR, hi);
      req <= 16'h0002;
      bus(1, `SEL_HIGH_ADDR, hi);
      lines(16'h0002);
      repeat (3) @(posedge CLK);
      summarize();
   end
endmodule // test_irq_source_selector
